// ==== rtl/pdu_datapath.sv ====
/*
 Programmable datapath unit: ALU, working registers, two queues, configuration store,
 compares, status and control. Assumes a synchronous register port driven by the system bus
 and routing-fabric signals synchronous to clk.
*/
`timescale 1ns/1ps
`include "pdu_params.svh"
//Function
//- ALU works on 8-bit operands and finishes each operation in one cycle.
//- Four working registers, all reachable by the bus during operation.
//- Accumulators feed and receive the ALU and feed the compares.
//- Data registers feed ALU and compares, never receive ALU results.
//- Four-byte queues load registers or capture accumulators or ALU output.
//- Eight 16-bit configuration words, one chosen each cycle by routing address.
//- ALU has eight functions: inc, dec, add, sub, and, or, xor, pass.
//- Shift left, shift right, nibble swap and OR mask follow the ALU.
//- Two masked comparators with selectable operand pairings.
//- Zero, all-ones and overflow conditions; selected conditions drive routing outputs.
//- Programmable most significant bit for arithmetic and shifting.
//- One CRC or pseudo_random_sequence step per cycle with programmable polynomial.
//- Each queue independently an input or an output buffer.
//- Queue status selectable onto routing outputs.
//- Carries, shift data and compare pass to and from neighbour datapaths.
//- Carry and shift out registered; carry selectable as a later carry input.
//- Six routing inputs and six routing outputs.
//- Bus-written control register bits drive the routing fabric.
//- Read-only status register returns routing-fabric signal states.
//- Sticky status bits latch conditions and clear when read.
//- Datapath and status-control each have their own enable.
module pdu_datapath (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  // Register port
  input  wire logic                    bus_sel,
  input  wire logic                    bus_we,
  input  wire logic [5:0]              bus_addr,
  input  wire logic [7:0]              bus_wdata,
  output logic      [7:0]              bus_rdata,
  output logic                         bus_ack,
  // Routing fabric
  input  wire pdu_pkg::pdu_route_in_t  route_in,
  input  wire logic [7:0]              status_in,
  output logic      [7:0]              ctrl_out,
  output logic      [5:0]              route_out,
  // Chaining
  input  wire logic                    chain_ci,
  input  wire logic                    chain_si,
  input  wire logic                    chain_cmp_in,
  output logic                         chain_co,
  output logic                         chain_so,
  output logic                         chain_cmp_out,
  // Result stream
  output logic                         res_valid,
  output logic      [7:0]              res_data,
  input  wire logic                    res_ready
);
  import pdu_pkg::*;

  pdu_state_t r_reg, r_next;
  pdu_cfg_t   cfg;
  logic [2:0] msb;
  logic [7:0] wm, opa, opb, alu, sh, fin, cmp_b0, cmp_b1;
  logic [8:0] sum;
  logic       cin, cout, ovf, si, so, fb, step, stall, zero, ones;
  logic [15:0] cond;
  logic       ce0, cl0, ce1, cl1, q0_empty, q0_full, q1_empty, q1_full;
  logic       bus_rd, bus_wr, q0_pop_dp, q1_pop_dp, q0_push_dp, q1_push_dp;
  logic       q0_pop_bus, q1_pop_bus, q0_push_bus, q1_push_bus, push_ob;
  logic [7:0] q0_head, q1_head;

  always_comb begin
    r_next = r_reg;
    cfg = pdu_cfg_t'(r_reg.cfg_mem[route_in.cfg_addr[2:0]]);
    msb = r_reg.mode[`PDU_MODE_MSB_LO +: 3];
    wm = 8'hff >> (3'h7 - msb);
    unique case (cfg.opa)
      2'h0: opa = r_reg.acc0;
      2'h1: opa = r_reg.acc1;
      2'h2: opa = r_reg.dat0;
      default: opa = r_reg.dat1;
    endcase
    unique case (cfg.opb)
      2'h0: opb = r_reg.acc0;
      2'h1: opb = r_reg.acc1;
      2'h2: opb = r_reg.dat0;
      default: opb = r_reg.dat1;
    endcase
    unique case (cfg.cin)
      2'h0: cin = 1'b0;
      2'h1: cin = 1'b1;
      2'h2: cin = r_reg.carry;
      default: cin = chain_ci;
    endcase
    sum = 9'h000;
    ovf = 1'b0;
    unique case (cfg.func)
      PDU_INC: sum = {1'b0, opa & wm} + 9'h001;
      PDU_DEC: sum = {1'b0, opa & wm} + {1'b0, wm};
      PDU_ADD: sum = {1'b0, opa & wm} + {1'b0, opb & wm} + {8'h00, cin};
      PDU_SUB: sum = {1'b0, opa & wm} + {1'b0, ~opb & wm} + {8'h00, cin};
      PDU_AND: sum = {1'b0, opa & opb};
      PDU_OR:  sum = {1'b0, opa | opb};
      PDU_XOR: sum = {1'b0, opa ^ opb};
      PDU_PASS: sum = {1'b0, opa};
    endcase
    alu = sum[7:0];
    cout = (msb == 3'h7) ? sum[8] : sum[msb + 3'h1];
    if (cfg.func == PDU_ADD) begin
      ovf = (opa[msb] == opb[msb]) && (alu[msb] != opa[msb]);
    end else if (cfg.func == PDU_SUB) begin
      ovf = (opa[msb] != opb[msb]) && (alu[msb] != opa[msb]);
    end
    si = r_reg.mode2[`PDU_MODE2_CHAIN] ? chain_si : route_in.ser_in;
    fb = alu[msb] ^ si;
    so = 1'b0;
    unique case (cfg.shift)
      PDU_SH_LEFT: begin
        so = alu[msb];
        if (r_reg.mode[`PDU_MODE_CRC]) begin
          sh = {alu[6:0], 1'b0} ^ (fb ? r_reg.poly : 8'h00);
        end else begin
          sh = {alu[6:0], si};
        end
      end
      PDU_SH_RIGHT: begin
        so = alu[0];
        sh = ({1'b0, alu[7:1]} & ~(8'h01 << msb)) | ({7'h00, si} << msb);
      end
      PDU_SH_SWAP: sh = {alu[3:0], alu[7:4]};
      default: sh = alu;
    endcase
    if (cfg.qop == 2'h3) begin
      sh = sh | r_reg.ormask;
    end
    fin = (sh & wm) | (opa & ~wm);
    zero = (fin & wm) == 8'h00;
    ones = (fin & wm) == wm;
    cmp_b0 = r_reg.mode2[`PDU_MODE2_CMP0] ? r_reg.acc1 : r_reg.dat0;
    cmp_b1 = r_reg.mode2[`PDU_MODE2_CMP1] ? r_reg.acc0 : r_reg.acc1;
    ce0 = ((r_reg.acc0 ^ cmp_b0) & r_reg.cmpmask) == 8'h00;
    cl0 = (r_reg.acc0 & r_reg.cmpmask) < (cmp_b0 & r_reg.cmpmask);
    ce1 = ((cmp_b1 ^ r_reg.dat1) & r_reg.cmpmask) == 8'h00;
    cl1 = (cmp_b1 & r_reg.cmpmask) < (r_reg.dat1 & r_reg.cmpmask);
    if (r_reg.mode2[`PDU_MODE2_CHAIN]) begin
      ce0 = ce0 & chain_cmp_in;
    end
    q0_empty = r_reg.q0_cnt == 3'h0;
    q0_full = r_reg.q0_cnt == 3'(`PDU_Q_DEPTH);
    q1_empty = r_reg.q1_cnt == 3'h0;
    q1_full = r_reg.q1_cnt == 3'(`PDU_Q_DEPTH);
    q0_head = r_reg.q0_mem[r_reg.q0_rd];
    q1_head = r_reg.q1_mem[r_reg.q1_rd];
    cond = {1'b0, r_reg.ov[0], chain_cmp_in, q1_full, q1_empty, q0_full, q0_empty, r_reg.sout,
            r_reg.carry, ovf, ones, zero, cl1, ce1, cl0, ce0};

    // Datapath step; a full result buffer stalls the whole step of a word with emit set
    stall = cfg.emit && r_reg.ov[1];
    step = route_in.dp_en && !stall;
    q0_pop_dp = step && cfg.qop == 2'h1 && !r_reg.mode[`PDU_MODE_Q0_DIR] && !q0_empty;
    q1_pop_dp = step && cfg.qop == 2'h1 && !r_reg.mode[`PDU_MODE_Q1_DIR] && !q1_empty;
    q0_push_dp = step && cfg.qop == 2'h2 && r_reg.mode[`PDU_MODE_Q0_DIR] && !q0_full;
    q1_push_dp = step && cfg.qop == 2'h2 && r_reg.mode[`PDU_MODE_Q1_DIR] && !q1_full;
    push_ob = step && cfg.emit;
    bus_rd = bus_sel && !bus_we && !r_reg.ack;
    bus_wr = bus_sel && bus_we && !r_reg.ack;
    q0_push_bus = bus_wr && bus_addr == `PDU_OFF_Q0 && !r_reg.mode[`PDU_MODE_Q0_DIR] && !q0_full;
    q1_push_bus = bus_wr && bus_addr == `PDU_OFF_Q1 && !r_reg.mode[`PDU_MODE_Q1_DIR] && !q1_full;
    q0_pop_bus = bus_rd && bus_addr == `PDU_OFF_Q0 && r_reg.mode[`PDU_MODE_Q0_DIR] && !q0_empty;
    q1_pop_bus = bus_rd && bus_addr == `PDU_OFF_Q1 && r_reg.mode[`PDU_MODE_Q1_DIR] && !q1_empty;

    if (step) begin
      if (cfg.dst[0]) begin
        r_next.acc0 = fin;
      end
      if (cfg.dst[1]) begin
        r_next.acc1 = fin;
      end
      if (cfg.shift != PDU_SH_NONE) begin
        r_next.sout = so;
      end
      if (cfg.func inside {PDU_INC, PDU_DEC, PDU_ADD, PDU_SUB}) begin
        r_next.carry = cout;
      end
    end
    if (q0_pop_dp) begin
      if (r_reg.mode[`PDU_MODE_LD_DAT]) begin
        r_next.dat0 = q0_head;
      end else begin
        r_next.acc0 = q0_head;
      end
    end
    if (q1_pop_dp) begin
      if (r_reg.mode[`PDU_MODE_LD_DAT]) begin
        r_next.dat1 = q1_head;
      end else begin
        r_next.acc1 = q1_head;
      end
    end
    if (q0_push_dp || q0_push_bus) begin
      r_next.q0_mem[r_reg.q0_wr] = q0_push_bus ? bus_wdata : (r_reg.mode[`PDU_MODE_Q_ACC] ? r_reg.acc0 : fin);
      r_next.q0_wr = r_reg.q0_wr + 2'h1;
    end
    if (q1_push_dp || q1_push_bus) begin
      r_next.q1_mem[r_reg.q1_wr] = q1_push_bus ? bus_wdata : (r_reg.mode[`PDU_MODE_Q_ACC] ? r_reg.acc1 : fin);
      r_next.q1_wr = r_reg.q1_wr + 2'h1;
    end
    if (q0_pop_dp || q0_pop_bus) begin
      r_next.q0_rd = r_reg.q0_rd + 2'h1;
    end
    if (q1_pop_dp || q1_pop_bus) begin
      r_next.q1_rd = r_reg.q1_rd + 2'h1;
    end
    r_next.q0_cnt = r_reg.q0_cnt + 3'((q0_push_dp || q0_push_bus) ? 1 : 0) - 3'((q0_pop_dp || q0_pop_bus) ? 1 : 0);
    r_next.q1_cnt = r_reg.q1_cnt + 3'((q1_push_dp || q1_push_bus) ? 1 : 0) - 3'((q1_pop_dp || q1_pop_bus) ? 1 : 0);

    // Two-entry result buffer
    if (res_ready && r_reg.ov[0]) begin
      r_next.ob[0] = r_reg.ob[1];
      r_next.ov = {1'b0, r_reg.ov[1]};
    end
    if (push_ob) begin
      if (!r_next.ov[0]) begin
        r_next.ob[0] = fin;
        r_next.ov[0] = 1'b1;
      end else begin
        r_next.ob[1] = fin;
        r_next.ov[1] = 1'b1;
      end
    end

    // Register port; a bus write wins over a datapath update in the same cycle
    // A request held into its ack cycle is taken only once
    r_next.ack = bus_sel && !r_reg.ack;
    r_next.rdata = 8'h00;
    if (bus_wr) begin
      unique case (bus_addr)
        `PDU_OFF_ACC0:    r_next.acc0 = bus_wdata;
        `PDU_OFF_ACC1:    r_next.acc1 = bus_wdata;
        `PDU_OFF_DAT0:    r_next.dat0 = bus_wdata;
        `PDU_OFF_DAT1:    r_next.dat1 = bus_wdata;
        `PDU_OFF_CTRL:    r_next.ctrl = bus_wdata;
        `PDU_OFF_CMPMASK: r_next.cmpmask = bus_wdata;
        `PDU_OFF_POLY:    r_next.poly = bus_wdata;
        `PDU_OFF_ORMASK:  r_next.ormask = bus_wdata;
        `PDU_OFF_MODE:    r_next.mode = bus_wdata;
        `PDU_OFF_MODE2:   r_next.mode2 = bus_wdata;
        `PDU_OFF_STKMASK: r_next.stkmask = bus_wdata;
        `PDU_OFF_OSEL01:  r_next.osel[7:0] = bus_wdata;
        `PDU_OFF_OSEL23:  r_next.osel[15:8] = bus_wdata;
        `PDU_OFF_OSEL45:  r_next.osel[23:16] = bus_wdata;
        default: begin
          if (bus_addr[5:4] == 2'h2) begin
            r_next.cfg_mem[bus_addr[3:1]][bus_addr[0]*8 +: 8] = bus_wdata;
          end
        end
      endcase
    end
    if (bus_rd) begin
      unique case (bus_addr)
        `PDU_OFF_ACC0:    r_next.rdata = r_reg.acc0;
        `PDU_OFF_ACC1:    r_next.rdata = r_reg.acc1;
        `PDU_OFF_DAT0:    r_next.rdata = r_reg.dat0;
        `PDU_OFF_DAT1:    r_next.rdata = r_reg.dat1;
        `PDU_OFF_Q0:      r_next.rdata = q0_pop_bus ? q0_head : 8'h00;
        `PDU_OFF_Q1:      r_next.rdata = q1_pop_bus ? q1_head : 8'h00;
        `PDU_OFF_CTRL:    r_next.rdata = r_reg.ctrl;
        `PDU_OFF_STAT:    r_next.rdata = (status_in & ~r_reg.stkmask) | r_reg.sticky;
        `PDU_OFF_CMPMASK: r_next.rdata = r_reg.cmpmask;
        `PDU_OFF_POLY:    r_next.rdata = r_reg.poly;
        `PDU_OFF_ORMASK:  r_next.rdata = r_reg.ormask;
        `PDU_OFF_MODE:    r_next.rdata = r_reg.mode;
        `PDU_OFF_MODE2:   r_next.rdata = r_reg.mode2;
        `PDU_OFF_STKMASK: r_next.rdata = r_reg.stkmask;
        `PDU_OFF_OSEL01:  r_next.rdata = r_reg.osel[7:0];
        `PDU_OFF_OSEL23:  r_next.rdata = r_reg.osel[15:8];
        `PDU_OFF_OSEL45:  r_next.rdata = r_reg.osel[23:16];
        default: begin
          if (bus_addr[5:4] == 2'h2) begin
            r_next.rdata = r_reg.cfg_mem[bus_addr[3:1]][bus_addr[0]*8 +: 8];
          end
        end
      endcase
    end

    // Status and control unit; set wins over clear-on-read
    if (route_in.sc_en) begin
      r_next.sticky = r_reg.sticky;
      if (bus_rd && bus_addr == `PDU_OFF_STAT) begin
        r_next.sticky = 8'h00;
      end
      r_next.sticky = r_next.sticky | (status_in & r_reg.stkmask);
    end
    for (int i = 0; i < 6; i++) begin
      r_next.rout[i] = cond[r_reg.osel[i*4 +: 4]];
    end
    r_next.chain_co = r_next.carry;
    r_next.chain_so = r_next.sout;
    r_next.chain_cmp = ce0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
      r_reg.cmpmask <= `PDU_RST_CMPMASK;
      r_reg.mode <= `PDU_RST_MODE;
      r_reg.osel <= {3{`PDU_RST_OSEL}};
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  assign bus_rdata = r_reg.rdata;
  assign bus_ack = r_reg.ack;
  assign ctrl_out = r_reg.ctrl;
  assign route_out = r_reg.rout;
  assign chain_co = r_reg.chain_co;
  assign chain_so = r_reg.chain_so;
  assign chain_cmp_out = r_reg.chain_cmp;
  assign res_valid = r_reg.ov[0];
  assign res_data = r_reg.ob[0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_q0_bound;
    r_reg.q0_cnt <= 3'(`PDU_Q_DEPTH);
  endproperty
  a_q0_bound: assert property (p_q0_bound) else $error("queue 0 count beyond depth");

  property p_full_write;
    clk_en && bus_sel && bus_we && bus_addr == `PDU_OFF_Q0 && q0_full
      |=> $stable(r_reg.q0_mem) && (q0_full || $past(q0_pop_dp));
  endproperty
  a_full_write: assert property (p_full_write) else $error("write to full queue changed it");

  property p_sticky_clear;
    clk_en && route_in.sc_en && bus_sel && !bus_ack && !bus_we && bus_addr == `PDU_OFF_STAT && status_in == 8'h00
      |=> r_reg.sticky == 8'h00;
  endproperty
  a_sticky_clear: assert property (p_sticky_clear) else $error("sticky not cleared by read");

  property p_sticky_set;
    clk_en && route_in.sc_en |=> (r_reg.sticky & $past(status_in & r_reg.stkmask)) == $past(status_in & r_reg.stkmask);
  endproperty
  a_sticky_set: assert property (p_sticky_set) else $error("sticky event lost");

  property p_ctrl_write;
    clk_en && bus_sel && bus_we && bus_addr == `PDU_OFF_CTRL |=> ctrl_out == $past(bus_wdata);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write not seen");

  property p_ack;
    clk_en && bus_sel && !bus_ack |=> bus_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("bus access not answered");

  property p_no_dat_write;
    clk_en && !bus_sel && !q0_pop_dp && !q1_pop_dp |=> $stable(r_reg.dat0) && $stable(r_reg.dat1);
  endproperty
  a_no_dat_write: assert property (p_no_dat_write) else $error("data register took ALU result");

  property p_add_dst;
    clk_en && step && !bus_sel && !q0_pop_dp && cfg.dst == 2'h1 && cfg.func == PDU_ADD && cfg.shift == PDU_SH_NONE
      && cfg.qop == 2'h0 && wm == 8'hff |=> r_reg.acc0 == $past(8'(opa + opb + {7'h00, cin}));
  endproperty
  a_add_dst: assert property (p_add_dst) else $error("single-cycle add wrong");

  property p_hold_stall;
    res_valid && !res_ready && clk_en |=> res_valid && $stable(res_data);
  endproperty
  a_hold_stall: assert property (p_hold_stall) else $error("result lost under stall");

  c_stall: cover property (clk_en && stall);
  c_q0_full: cover property (q0_full);
  c_sticky: cover property (r_reg.sticky != 8'h00 ##1 r_reg.sticky == 8'h00);
  c_crc: cover property (step && r_reg.mode[`PDU_MODE_CRC] && cfg.shift == PDU_SH_LEFT && fb);
endmodule

// ==== common/pdu_params.svh ====
/*
 Offsets, field positions, reset values and counts of the programmable datapath unit.
 Assumes inclusion by bare name from the package, the datapath and the bench.
*/
`ifndef PDU_PARAMS_SVH
`define PDU_PARAMS_SVH
`define PDU_ADDR_W        6
`define PDU_OFF_ACC0      6'h00
`define PDU_OFF_ACC1      6'h01
`define PDU_OFF_DAT0      6'h02
`define PDU_OFF_DAT1      6'h03
`define PDU_OFF_Q0        6'h04
`define PDU_OFF_Q1        6'h05
`define PDU_OFF_CTRL      6'h06
`define PDU_OFF_STAT      6'h07
`define PDU_OFF_CMPMASK   6'h08
`define PDU_OFF_POLY      6'h09
`define PDU_OFF_ORMASK    6'h0a
`define PDU_OFF_MODE      6'h0b
`define PDU_OFF_MODE2     6'h0c
`define PDU_OFF_STKMASK   6'h0d
`define PDU_OFF_OSEL01    6'h0e
`define PDU_OFF_OSEL23    6'h0f
`define PDU_OFF_OSEL45    6'h10
`define PDU_OFF_CFG_BASE  6'h20
`define PDU_MODE_MSB_LO   0
`define PDU_MODE_CRC      3
`define PDU_MODE_Q0_DIR   4
`define PDU_MODE_Q1_DIR   5
`define PDU_MODE_LD_DAT   6
`define PDU_MODE_Q_ACC    7
`define PDU_MODE2_CMP0    0
`define PDU_MODE2_CMP1    1
`define PDU_MODE2_CHAIN   2
`define PDU_RST_BYTE      8'h00
`define PDU_RST_CMPMASK   8'hff
`define PDU_RST_MODE      8'h07
`define PDU_RST_OSEL      8'hff
`define PDU_Q_DEPTH       4
`define PDU_CFG_WORDS     8
`endif

// ==== common/pdu_pkg.sv ====
/*
 Types of the programmable datapath unit: configuration word, ALU functions, state record.
 Assumes pdu_params.svh on the include path.
*/
package pdu_pkg;
  `include "pdu_params.svh"
  typedef enum logic [2:0] {PDU_INC, PDU_DEC, PDU_ADD, PDU_SUB, PDU_AND, PDU_OR, PDU_XOR, PDU_PASS} pdu_alu_t;
  typedef enum logic [1:0] {PDU_SH_NONE, PDU_SH_LEFT, PDU_SH_RIGHT, PDU_SH_SWAP} pdu_shift_t;
  typedef struct packed {
    pdu_alu_t   func;
    logic [1:0] opa;
    logic [1:0] opb;
    logic [1:0] dst;
    pdu_shift_t shift;
    logic [1:0] cin;
    logic [1:0] qop;
    logic       emit;
  } pdu_cfg_t;
  typedef struct packed {
    logic [5:0] cfg_addr;
    logic       ser_in;
    logic       dp_en;
    logic       sc_en;
  } pdu_route_in_t;
  typedef struct packed {
    logic [7:0] acc0, acc1, dat0, dat1;
    logic [3:0][7:0] q0_mem, q1_mem;
    logic [1:0] q0_rd, q0_wr, q1_rd, q1_wr;
    logic [2:0] q0_cnt, q1_cnt;
    logic [7:0][15:0] cfg_mem;
    logic       carry, sout;
    logic [7:0] ctrl, sticky, stkmask, cmpmask, poly, ormask, mode, mode2;
    logic [23:0] osel;
    logic [7:0] rdata;
    logic       ack;
    logic [5:0] rout;
    logic       chain_co, chain_so, chain_cmp;
    logic [1:0][7:0] ob;
    logic [1:0] ov;
  } pdu_state_t;
endpackage

// ==== bench/pdu_bus_host.sv ====
/*
 Bus host model for the datapath unit: each request held until the edge that samples the ack.
 Assumes a free-running clk and an ack within eight cycles of the request.
*/
`timescale 1ns/1ps
module pdu_bus_host (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic            bus_sel,
  output logic            bus_we,
  output logic [5:0]      bus_addr,
  output logic [7:0]      bus_wdata,
  input  wire logic [7:0] bus_rdata,
  input  wire logic       bus_ack
);
  initial begin
    bus_sel = 1'b0;
    bus_we = 1'b0;
    bus_addr = 6'h00;
    bus_wdata = 8'h00;
  end

  // One access: request held until the ack edge, answer taken at that edge
  task automatic xfer(input logic we, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    bus_sel = 1'b1;
    bus_we = we;
    bus_addr = a;
    bus_wdata = d;
    @(posedge clk);
    while (bus_ack !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    q = (bus_ack === 1'b1) ? bus_rdata : 8'hxx;
    #1;
    bus_sel = 1'b0;
    bus_we = ~we;
    bus_addr = ~a;
    bus_wdata = ~d;
  endtask
endmodule

// ==== bench/tb_top.sv ====
/*
 Self-checking bench of the datapath unit: registers, ALU, carry, queues, status, stream.
 Assumes pdu_pkg compiled first and the bus host model beside the unit.
*/
`timescale 1ns/1ps
`include "pdu_params.svh"
module tb_top;
  import pdu_pkg::*;
  logic          clk, rst_n, clk_en, bus_sel, bus_we, bus_ack, res_valid, res_ready;
  logic          chain_ci, chain_si, chain_cmp_in, chain_co, chain_so, chain_cmp_out;
  logic [5:0]    bus_addr, route_out;
  logic [7:0]    bus_wdata, bus_rdata, status_in, ctrl_out, res_data, q, a, b;
  logic [7:0]    d [5];
  pdu_route_in_t route_in;
  int            bad_count, cmp_count;

  pdu_datapath pdu_datapath_inst (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .bus_sel(bus_sel),
    .bus_we(bus_we), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack), .route_in(route_in), .status_in(status_in), .ctrl_out(ctrl_out),
    .route_out(route_out), .chain_ci(chain_ci), .chain_si(chain_si), .chain_cmp_in(chain_cmp_in),
    .chain_co(chain_co), .chain_so(chain_so), .chain_cmp_out(chain_cmp_out),
    .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready));
  pdu_bus_host pdu_bus_host_inst (.clk(clk), .bus_sel(bus_sel), .bus_we(bus_we),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic final_report;
    $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] ad, input logic [7:0] v);
    pdu_bus_host_inst.xfer(1'b1, ad, v, q);
  endtask

  task automatic rd(input logic [5:0] ad, input logic [7:0] exp, input string what);
    pdu_bus_host_inst.xfer(1'b0, ad, 8'h00, q);
    chk(q, exp, what);
  endtask

  task automatic cfg(input int i, input logic [15:0] w);
    wr(6'(`PDU_OFF_CFG_BASE + 2 * i), w[7:0]);
    wr(6'(`PDU_OFF_CFG_BASE + 2 * i + 1), w[15:8]);
  endtask

  // Datapath runs for n edges on configuration word ci
  task automatic step(input logic [2:0] ci, input int n);
    @(posedge clk);
    #1;
    route_in.cfg_addr = {3'b000, ci};
    route_in.dp_en = 1'b1;
    repeat (n) @(posedge clk);
    #1;
    route_in.dp_en = 1'b0;
  endtask

  function automatic logic [15:0] mk(input logic [2:0] f, input logic [1:0] oa, ob, ds, qo, input logic em);
    return {f, oa, ob, ds, 2'b00, 2'b00, qo, em};
  endfunction

  function automatic logic [7:0] exp_alu(input logic [2:0] f, input logic [7:0] x, y);
    case (f)
      3'd0: return x + 8'h01;
      3'd1: return x - 8'h01;
      3'd2: return x + y;
      3'd3: return x - y;
      3'd4: return x & y;
      3'd5: return x | y;
      3'd6: return x ^ y;
      default: return x;
    endcase
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    route_in = '{cfg_addr: 6'h00, ser_in: 1'b0, dp_en: 1'b0, sc_en: 1'b1};
    status_in = 8'h00;
    chain_ci = 1'b0;
    chain_si = 1'b0;
    chain_cmp_in = 1'b0;
    res_ready = 1'b0;
    void'($urandom(32'hfca514f5));
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd(`PDU_OFF_CMPMASK, 8'hff, "cmpmask reset");
    rd(`PDU_OFF_MODE, 8'h07, "mode reset");
    rd(`PDU_OFF_ACC1, 8'h00, "acc1 reset");
    rd(6'h11, 8'h00, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      a = 8'($urandom);
      wr(6'(i), a);
      rd(6'(i), a, "working register");
    end
    a = 8'($urandom);
    wr(`PDU_OFF_CTRL, a);
    chk(ctrl_out, a, "control out");
    status_in = 8'($urandom);
    wr(`PDU_OFF_STAT, 8'h5a);
    rd(`PDU_OFF_STAT, status_in, "status read");
    wr(`PDU_OFF_STKMASK, 8'h01);
    status_in = 8'h01;
    @(posedge clk);
    #1;
    status_in = 8'h00;
    rd(`PDU_OFF_STAT, 8'h01, "sticky held");
    rd(`PDU_OFF_STAT, 8'h00, "sticky cleared");
    $display("test registers done");
    for (int f = 0; f < 8; f++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      wr(`PDU_OFF_ACC0, a);
      wr(`PDU_OFF_DAT0, b);
      cfg(0, mk(3'(f), 2'd0, 2'd2, 2'b01, 2'd0, 1'b0) | ((f == 3) ? 16'h0008 : 16'h0000));
      step(3'd0, 1);
      rd(`PDU_OFF_ACC0, exp_alu(3'(f), a, b), "alu result");
      rd(`PDU_OFF_DAT0, b, "data register kept");
    end
    a = 8'($urandom);
    wr(`PDU_OFF_ACC0, a);
    cfg(0, mk(3'd7, 2'd0, 2'd2, 2'b01, 2'd0, 1'b0) | 16'h0060);
    step(3'd0, 1);
    rd(`PDU_OFF_ACC0, {a[3:0], a[7:4]}, "nibble swap");
    wr(`PDU_OFF_ACC0, 8'h3c);
    wr(`PDU_OFF_DAT0, 8'h3c);
    chk({7'h00, chain_cmp_out}, 8'h01, "compare chained");
    wr(`PDU_OFF_ACC0, 8'hff);
    wr(`PDU_OFF_DAT0, 8'h01);
    cfg(0, mk(3'd2, 2'd0, 2'd2, 2'b01, 2'd0, 1'b0));
    cfg(1, mk(3'd2, 2'd0, 2'd2, 2'b01, 2'd0, 1'b0) | 16'h0010);
    step(3'd0, 1);
    chk({7'h00, chain_co}, 8'h01, "carry out chained");
    step(3'd1, 1);
    rd(`PDU_OFF_ACC0, 8'h02, "carry reused");
    clk_en = 1'b0;
    step(3'd1, 2);
    clk_en = 1'b1;
    rd(`PDU_OFF_ACC0, 8'h02, "frozen by enable");
    $display("test alu done");
    wr(`PDU_OFF_OSEL01, 8'h9a);
    repeat (2) @(posedge clk);
    #1;
    chk({2'b00, route_out}, 8'h02, "queue empty out");
    for (int i = 0; i < 5; i++) begin
      d[i] = 8'($urandom);
      wr(`PDU_OFF_Q0, d[i]);
    end
    repeat (2) @(posedge clk);
    #1;
    chk({2'b00, route_out}, 8'h01, "queue full out");
    rd(`PDU_OFF_Q0, 8'h00, "input queue read");
    cfg(2, mk(3'd7, 2'd0, 2'd2, 2'b00, 2'd1, 1'b0));
    for (int i = 0; i < 4; i++) begin
      step(3'd2, 1);
      rd(`PDU_OFF_ACC0, d[i], "queue pop");
    end
    chk({2'b00, route_out}, 8'h02, "queue drained");
    wr(`PDU_OFF_MODE, 8'h17);
    cfg(3, mk(3'd7, 2'd0, 2'd2, 2'b00, 2'd2, 1'b0));
    a = 8'($urandom);
    wr(`PDU_OFF_ACC0, a);
    step(3'd3, 1);
    rd(`PDU_OFF_Q0, a, "output queue");
    rd(`PDU_OFF_Q0, 8'h00, "empty output read");
    wr(`PDU_OFF_MODE, 8'h07);
    $display("test queues done");
    cfg(4, mk(3'd7, 2'd0, 2'd2, 2'b00, 2'd0, 1'b1));
    a = 8'($urandom);
    wr(`PDU_OFF_ACC0, a);
    step(3'd4, 4);
    chk({7'h00, res_valid}, 8'h01, "stream held");
    chk(res_data, a, "stream data");
    res_ready = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, res_valid}, 8'h00, "stream drained");
    $display("test stream done");
    final_report();
  end
endmodule
